// *** logic/dev_status_link_caps_regs.vh ***
// Purpose: offsets, field positions, reset values and fixed codes
// Assumes: byte offsets in configuration space
// Notes: definitions only
`ifndef DEV_STATUS_LINK_CAPS_REGS_VH
`define DEV_STATUS_LINK_CAPS_REGS_VH
`define DEVICE_STATUS_OFFSET 8'h7A
`define LINK_CAPABILITIES_OFFSET 8'h7C
`define LINK_CONTROL_OFFSET 8'h80
`define DIAG_CONTROL1_OFFSET 8'hC4
`define DEVICE_STATUS_RESET 16'h0000
`define DS_OUTSTANDING_BIT 5
`define DS_AUX_BIT 4
`define DS_UNSUPPORTED_BIT 3
`define DS_FATAL_BIT 2
`define DS_NONFATAL_BIT 1
`define DS_CORRECTABLE_BIT 0
`define LC_COMMON_CLOCK_BIT 6
`define LCAP_PORT_NUM 8'h00
`define LCAP_RESERVED 2'h0
`define LCAP_BW_NOTIFY 1'h0
`define LCAP_LINK_ACTIVE 1'h0
`define LCAP_SURPRISE_DOWN 1'h0
`define LCAP_CLOCK_PM 1'h1
`define LCAP_STANDBY_COMMON 3'h3
`define LCAP_STANDBY_ASYNC 3'h4
`define LCAP_ASPM_SUPPORT 2'h3
`define LCAP_MAX_WIDTH 6'h01
`define LCAP_MAX_SPEED 4'h1
`define DIAG_UPPER_HI 20
`define DIAG_UPPER_LO 18
`define DIAG_LOWER_HI 17
`define DIAG_LOWER_LO 15
`endif

// *** logic/error_flag_bank.v ***
// Purpose: sticky error flags, cleared by writing ones
// Assumes: event inputs are on core_clk
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ns
module error_flag_bank #(
	parameter WIDTH = 4
) (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// events and clear
	input wire [WIDTH-1:0] set_event,
	input wire [WIDTH-1:0] clear_mask,
	// state
	output reg [WIDTH-1:0] flags
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_flag
			always @(posedge core_clk or posedge rst)
			begin
				if (rst)
					flags[i] <= 1'b0;
				else if (set_event[i])
					flags[i] <= 1'b1;
				else if (clear_mask[i])
					flags[i] <= 1'b0;
			end
		end
	endgenerate
endmodule // error_flag_bank

// *** logic/level_sync.v ***
// Purpose: two-flop synchroniser for a pin level
// Assumes: input is asynchronous to core_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module level_sync (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// levels
	input wire level_in,
	output reg level_out
);
	reg stage1;
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1 <= 1'b0;
			level_out <= 1'b0;
		end
		else
		begin
			stage1 <= level_in;
			level_out <= stage1;
		end
	end
endmodule // level_sync

// *** logic/pcie_dev_status_link_caps.v ***
// What this block does
// - bit 5 high while non-posted requests pending
// - bit 4 reports auxiliary supply presence
// - bit 3 set on unsupported request
// - bit 2 set on fatal error
// - bit 1 set on nonfatal error
// - bit 0 set on correctable error
// - status bits 15:6 read zero
// - port number zero in bits 31:24
// - capability bits 23:22 read zero
// - bits 21, 20, 19 hardwired zero
// - bit 18 hardwired one
// - common clock: bits 17:15 from diag 20:18
// - async clock: bits 17:15 from diag 17:15
// - common clock: bits 14:12 read 011b
// - async clock: bits 14:12 read 100b
// - bits 11:10 read 11b
// - bits 9:4 read 000001b
// - bits 3:0 read 1h
// - common clock from link control bit 6
//
// Purpose: device status and link capabilities configuration registers
// Assumes: config port with byte offset, one-cycle read/write strobes
// Notes: read data registered, valid one cycle after the read strobe
`timescale 1ns/1ns
`include "dev_status_link_caps_regs.vh"
module pcie_dev_status_link_caps (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// configuration access
	input wire [7:0] cfg_addr,
	input wire cfg_read,
	input wire cfg_write,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	output reg cfg_rvalid,
	// bridge state
	input wire nonposted_pending,
	input wire aux_supply_pin,
	input wire unsupported_request_event,
	input wire fatal_error_event,
	input wire nonfatal_error_event,
	input wire correctable_error_event,
	// neighbouring register fields
	input wire [15:0] link_control,
	input wire [31:0] diag_control1,
	// status view
	output wire [15:0] device_status,
	output wire [31:0] link_capabilities
);
	wire aux_supply_present;
	wire [3:0] err_flags;
	wire [3:0] err_events;
	wire [3:0] err_clear;
	wire common_clock;
	wire status_write;
	wire [2:0] deep_idle_exit_delay;
	wire [2:0] standby_exit_delay;
	reg outstanding_request_flag;

	level_sync u_aux_sync (
		.core_clk(core_clk),
		.rst(rst),
		.level_in(aux_supply_pin),
		.level_out(aux_supply_present)
	);

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			outstanding_request_flag <= 1'b0;
		else
			outstanding_request_flag <= nonposted_pending;
	end

	// event order: unsupported, fatal, nonfatal, correctable
	assign err_events = {unsupported_request_event, fatal_error_event,
		nonfatal_error_event, correctable_error_event};
	// status sits in the upper half of the dword at 78h
	assign status_write = cfg_write && (cfg_addr == `DEVICE_STATUS_OFFSET);
	assign err_clear = status_write ? cfg_wdata[`DS_UNSUPPORTED_BIT+16:16] : 4'h0;

	error_flag_bank #(
		.WIDTH(4)
	) u_flags (
		.core_clk(core_clk),
		.rst(rst),
		.set_event(err_events),
		.clear_mask(err_clear),
		.flags(err_flags)
	);

	// unused bits 15:6 are zero
	assign device_status = {10'h000, outstanding_request_flag, aux_supply_present,
		err_flags};

	assign common_clock = link_control[`LC_COMMON_CLOCK_BIT];
	assign deep_idle_exit_delay = common_clock ?
		diag_control1[`DIAG_UPPER_HI:`DIAG_UPPER_LO] :
		diag_control1[`DIAG_LOWER_HI:`DIAG_LOWER_LO];
	assign standby_exit_delay = common_clock ?
		`LCAP_STANDBY_COMMON :
		`LCAP_STANDBY_ASYNC;

	// fully combinational, no storage: writes have nowhere to land
	assign link_capabilities = {
		`LCAP_PORT_NUM,
		`LCAP_RESERVED,
		`LCAP_BW_NOTIFY, `LCAP_LINK_ACTIVE, `LCAP_SURPRISE_DOWN,
		`LCAP_CLOCK_PM,
		deep_idle_exit_delay,
		standby_exit_delay,
		`LCAP_ASPM_SUPPORT,
		`LCAP_MAX_WIDTH,
		`LCAP_MAX_SPEED
	};

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_rdata <= 32'h00000000;
			cfg_rvalid <= 1'b0;
		end
		else
		begin
			cfg_rvalid <= cfg_read;
			if (cfg_read)
			begin
				case (cfg_addr)
					`DEVICE_STATUS_OFFSET: cfg_rdata <= {16'h0000, device_status};
					`LINK_CAPABILITIES_OFFSET: cfg_rdata <= link_capabilities;
					default: cfg_rdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // pcie_dev_status_link_caps

// *** tb/caps_properties.sv ***
// Purpose: checks status and capability ports
// Assumes: one clock, reset high
// Notes: bound below
`timescale 1ns/1ns
module caps_properties (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// inputs
	input wire nonposted_pending,
	input wire aux_supply_pin,
	input wire unsupported_request_event,
	input wire fatal_error_event,
	input wire nonfatal_error_event,
	input wire correctable_error_event,
	input wire [15:0] link_control,
	input wire [31:0] diag_control1,
	// outputs
	input wire [15:0] device_status,
	input wire [31:0] link_capabilities
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_OUTSTANDING_REQUEST_FLAG:
	assert property (nonposted_pending |=> device_status[5]) else $error("outstanding_request_flag");
	AST_AUX:
	assert property (aux_supply_pin [*3] |-> device_status[4]) else $error("aux");
	AST_FATAL:
	assert property (fatal_error_event |=> device_status[2]) else $error("fatal");
	AST_RSVD:
	assert property (device_status[15:6] == 10'h000) else $error("rsvd");
	AST_FIXED:
	assert property (link_capabilities[31:18] == 14'h0001) else $error("fixed");
	AST_LOW:
	assert property (link_capabilities[11:0] == 12'hC11) else $error("low");
	AST_DEEP:
	assert property (link_capabilities[17:15] == (link_control[6] ?
		diag_control1[20:18] : diag_control1[17:15])) else $error("deep");
	AST_STBY:
	assert property (link_capabilities[14:12] == (link_control[6] ? 3'h3 : 3'h4))
		else $error("stby");
	AST_OUTSTANDING_REQUEST_FLAG_LOW:
	assert property (!nonposted_pending |=> !device_status[5]) else $error("outstanding_request_flag low");
	AST_AUX_LOW:
	assert property ((!aux_supply_pin) [*3] |-> !device_status[4]) else $error("aux low");
	AST_UNSUP:
	assert property (unsupported_request_event |=> device_status[3]) else $error("unsup");
	AST_NONFATAL:
	assert property (nonfatal_error_event |=> device_status[1]) else $error("nonfatal");
	AST_CORR:
	assert property (correctable_error_event |=> device_status[0]) else $error("corr");
endmodule // caps_properties
bind pcie_dev_status_link_caps caps_properties chk (.core_clk, .rst, .nonposted_pending,
	.aux_supply_pin, .unsupported_request_event, .fatal_error_event, .nonfatal_error_event,
	.correctable_error_event, .link_control, .diag_control1, .device_status,
	.link_capabilities);

// *** tb/test_pcie_dev_status_link_caps.sv ***
// Purpose: bench for status and capability registers
// Assumes: read answers one cycle later
// Notes: inputs change 1 ns after each rising edge
`timescale 1ns/1ns
module test_pcie_dev_status_link_caps;
	logic core_clk = 0, rst = 1, cfg_read = 0, cfg_write = 0;
	logic nonposted_pending = 0, aux_supply_pin = 0;
	logic [3:0] ev = 4'h0;
	logic [7:0] cfg_addr = 8'h00;
	logic [15:0] link_control = 16'h0000;
	logic [31:0] cfg_wdata = 32'h0, diag_control1 = 32'h0, rd_val, d, e;
	wire [31:0] cfg_rdata, link_capabilities;
	wire [15:0] device_status;
	wire cfg_rvalid;
	int err_total = 0, checked = 0, cyc = 0;
	pcie_dev_status_link_caps DUT (.core_clk, .rst, .cfg_addr, .cfg_read, .cfg_write,
		.cfg_wdata, .cfg_rdata, .cfg_rvalid, .nonposted_pending, .aux_supply_pin,
		.unsupported_request_event(ev[3]), .fatal_error_event(ev[2]),
		.nonfatal_error_event(ev[1]), .correctable_error_event(ev[0]),
		.link_control, .diag_control1, .device_status, .link_capabilities);
	initial
		forever #50 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (++cyc == 3000)
		begin
			err_total++;
			test_done;
		end
	task test_done;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task rd(input [7:0] a);
		@(posedge core_clk) #1 cfg_addr = a;
		cfg_read = 1;
		@(posedge core_clk) #1 cfg_read = 0;
		chk(cfg_rvalid, 1);
		rd_val = cfg_rdata;
	endtask
	task wr(input [7:0] a, input [31:0] v);
		@(posedge core_clk) #1 cfg_addr = a;
		cfg_wdata = v;
		cfg_write = 1;
		@(posedge core_clk) #1 cfg_write = 0;
	endtask
	task t_caps;
		for (int i = 0; i < 4; i++)
		begin
			link_control = i[0] ? 16'h0040 : 16'hFFBF;
			d = i[1] ? 32'h001C0000 : 32'hFFE3FFFF;
			diag_control1 = d;
			e = {14'h0001, i[0] ? d[20:18] : d[17:15], i[0] ? 3'h3 : 3'h4, 12'hC11};
			rd(8'h7C);
			chk(rd_val, e);
			wr(8'h7C, 32'hFFFFFFFF);
			rd(8'h7C);
			chk(rd_val, e);
		end
	endtask
	task t_status;
		nonposted_pending = 1;
		aux_supply_pin = 1;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk) #1 ev[i] = 1;
			@(posedge core_clk) #1 ev[i] = 0;
			chk(device_status[3:0], (2 << i) - 1);
		end
		rd(8'h7A);
		chk(rd_val, 32'h0000003F);
		nonposted_pending = 0;
		aux_supply_pin = 0;
		wr(8'h7A, 32'h000F0000);
		rd(8'h7A);
		chk(rd_val, 32'h0);
		rd(8'h7E);
		chk(rd_val, 32'h0);
	endtask
	task t_clear;
		@(posedge core_clk) #1 ev = 4'hF;
		@(posedge core_clk) #1 ev = 4'h0;
		wr(8'h7A, 32'h000A0005);
		rd(8'h7A);
		chk(rd_val, 32'h00000005);
		@(posedge core_clk) #1 cfg_addr = 8'h7A;
		cfg_wdata = 32'h000F0000;
		cfg_write = 1;
		ev = 4'h2;
		@(posedge core_clk) #1 cfg_write = 0;
		ev = 4'h0;
		chk(device_status, 32'h00000002);
		wr(8'h7C, 32'h000F0000);
		chk(device_status, 32'h00000002);
		@(posedge core_clk) #1 rst = 1;
		@(posedge core_clk) #1 rst = 0;
		chk(device_status, 32'h0);
		rd(8'h7C);
		chk(rd_val, e);
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		#1 rst = 0;
		chk(device_status, 32'h0);
		t_caps;
		t_status;
		t_clear;
		test_done;
	end
endmodule // test_pcie_dev_status_link_caps
